// File: verilog/lat_pkg.sv
/*
  constants, field layout and enumerations of the trigger/capture core.
  assumes a 32-bit apb slave decoding byte addresses in the low 8 bits.
*/
`default_nettype none
package lat_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD  = 8'h04;
  localparam logic [7:0] OFS_TVAL = 8'h08;
  localparam logic [7:0] OFS_TMSK = 8'h0c;
  localparam logic [7:0] OFS_CVAL = 8'h10;
  localparam logic [7:0] OFS_CMSK = 8'h14;
  localparam logic [7:0] OFS_GEOM = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_RADR = 8'h20;
  localparam logic [7:0] OFS_RDAT = 8'h24;
  localparam logic [7:0] OFS_MARK = 8'h28;
  // ==========================================================
  // field positions
  localparam int CTRL_TMODE_LSB = 0;
  localparam int CTRL_OMODE_LSB = 4;
  localparam int CTRL_CCOND_BIT = 6;
  localparam int CTRL_TCOMB_LSB = 8;
  localparam int CTRL_CCOMB_LSB = 10;
  localparam int CMD_ARM_BIT    = 0;
  localparam int CMD_IMM_BIT    = 1;
  localparam int CMD_STOP_BIT   = 2;
  localparam int GEOM_WDL_LSB   = 0;
  localparam int GEOM_WCL_LSB   = 8;
  localparam int GEOM_TPOS_LSB  = 16;
  localparam int STAT_WIN_LSB   = 8;
  localparam int STAT_CNT_LSB   = 20;
  // ==========================================================
  // reset values
  localparam logic [4:0] WCL_RST = 5'h00;
  // ==========================================================
  // enumerations
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_pre  = 5'h02,
    st_wait = 5'h04,
    st_post = 5'h08,
    st_full = 5'h10
  } state_t;
  typedef enum logic [2:0] {
    simple_only                       = 3'h0,
    sequencer_only                    = 3'h1,
    simple_condition_or_external_mode = 3'h2,
    sequencer_or_external_mode        = 3'h3,
    external_edge_only_mode           = 3'h4
  } tmode_t;
  typedef enum logic [1:0] {
    out_disabled                   = 2'h0,
    internal_to_output             = 2'h1,
    external_to_output             = 2'h2,
    internal_or_external_to_output = 2'h3
  } omode_t;
  typedef enum logic [1:0] {
    comb_and  = 2'h0,
    comb_or   = 2'h1,
    comb_nand = 2'h2,
    comb_nor  = 2'h3
  } comb_t;
endpackage
`default_nettype wire

// File: verilog/lat_core.sv
/*
  trigger and capture engine of an embedded logic analyzer with apb
  registers, windowed capture buffer and cross-trigger ports.
  assumes probes and cross-trigger inputs synchronous to clk_sys.
*/
// The APB interface to the registers and the address map are this design's own decisions.
// Function
// - combined modes trigger on cross-trigger input OR internal condition
// - edge-only mode triggers on rising cross-trigger input, ignores internals
// - output mode picks none, internal, input passthrough, or both ORed
// - cross-trigger ports active only when enabled by generation parameter
// - samples stored only in pre-trigger, waiting or post-trigger states
// - unconditional capture stores a sample every active cycle
// - conditional capture stores only when capture condition is true or on the trigger sample
// - capture condition is a global combination of probe comparators
// - buffer splits into equal power-of-two windows
// - each window records its own trigger mark
// - position zero: fill window 0, re-arm each next window until full
// - position zero: ready to trigger right after previous window's last sample
// - nonzero position: pre-trigger samples, then trigger, then rest of window
// - triggers during a new window's pre-trigger fill are dropped
// - trigger position is any sample index of the window
// - data depth is any power of two up to generated maximum
// - normal arm waits for the configured trigger event
// - immediate arm triggers at once ignoring trigger settings
// - default sequencer program triggers unconditionally in any configuration
// - arming goes to waiting if position zero, else pre-trigger
// - trigger at last index ends the window (full if last window), else post-trigger
// - combination is AND, OR, NAND or NOR over participants
`timescale 1ns/10ps
`default_nettype none
module lat_core
  import lat_pkg::*;
#(
  parameter int DEPTH  = 1024,
  parameter int NP     = 4,
  parameter int PW     = 8,
  parameter bit EN_XIN = 1'b1,
  parameter bit EN_XOUT = 1'b1
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // probed nets
  input  wire logic [NP*PW-1:0]  probe_data,
  // cross-trigger ports
  input  wire logic              cross_trigger_input,
  output logic                   cross_trigger_input_acknowledge,
  output logic                   cross_trigger_output,
  input  wire logic              cross_trigger_output_acknowledge
);
  localparam int AW = $clog2(DEPTH);
  localparam int DW = NP * PW;

  typedef struct packed {
    state_t        st;
    tmode_t        tmode;
    omode_t        omode;
    logic          ccond;
    comb_t         tcomb;
    comb_t         ccomb;
    logic [DW-1:0] tval;
    logic [DW-1:0] tmsk;
    logic [DW-1:0] cval;
    logic [DW-1:0] cmsk;
    logic [4:0]    wdl;
    logic [4:0]    wcl;
    logic [AW-1:0] tpos;
    logic [AW-1:0] win;
    logic [AW-1:0] cnt;
    logic [AW-1:0] rem;
    logic          imm;
    logic          ext_d;
    logic          xo;
    logic          xi_ack;
    logic [AW-1:0] radr;
    logic [31:0]   rdat;
  } core_t;

  core_t         r_ff;
  core_t         nxt_r;
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] mark [DEPTH];

  logic          acc, wr, addr_ok, cmd_wr;
  logic          ext, ext_rise, simple_hit, seq_hit, int_hit;
  logic          cond, trig, cap_hit, armed, take, we, ev, win_done;
  logic [AW:0]   wd;
  logic [AW-1:0] wmask, wlast, waddr, cnt_inc;

  // ==========================================================
  // comparators and global combination
  function automatic logic combine(input logic [DW-1:0] d,
                                   input logic [DW-1:0] v,
                                   input logic [DW-1:0] m,
                                   input comb_t c);
    logic any_t, any_f, part, hit;
    any_t = 1'b0;
    any_f = 1'b0;
    for (int p = 0; p < NP; p++) begin
      part = |m[p*PW +: PW];
      hit  = ~|((d[p*PW +: PW] ^ v[p*PW +: PW]) & m[p*PW +: PW]);
      any_t = any_t | (part & hit);
      any_f = any_f | (part & ~hit);
    end
    case (c)
      comb_and:  combine = ~any_f;
      comb_or:   combine = any_t;
      comb_nand: combine = any_f;
      default:   combine = ~any_t;
    endcase
  endfunction

  // ==========================================================
  // trigger evaluation
  always_comb begin
    ext        = EN_XIN & cross_trigger_input;
    ext_rise   = ext & ~r_ff.ext_d;
    simple_hit = combine(probe_data, r_ff.tval, r_ff.tmsk, r_ff.tcomb);
    seq_hit    = 1'b1;
    int_hit    = ((r_ff.tmode == sequencer_only) ||
                  (r_ff.tmode == sequencer_or_external_mode)) ? seq_hit : simple_hit;
    case (r_ff.tmode)
      simple_only:                       cond = simple_hit;
      sequencer_only:                    cond = seq_hit;
      simple_condition_or_external_mode: cond = simple_hit | ext;
      sequencer_or_external_mode:        cond = seq_hit | ext;
      default:                           cond = ext_rise;
    endcase
    trig    = r_ff.imm | cond;
    cap_hit = combine(probe_data, r_ff.cval, r_ff.cmsk, r_ff.ccomb);
  end

  // ==========================================================
  // window geometry and write strobe
  always_comb begin
    wd      = (AW+1)'(1) << r_ff.wdl;
    wmask   = AW'(wd - (AW+1)'(1));
    wlast   = AW'(((AW+1)'(1) << r_ff.wcl) - (AW+1)'(1));
    waddr   = AW'(r_ff.win << r_ff.wdl) | r_ff.cnt;
    cnt_inc = (r_ff.cnt + AW'(1)) & wmask;
    armed   = (r_ff.st == st_pre) || (r_ff.st == st_wait) ||
              (r_ff.st == st_post);
    take    = (r_ff.st == st_wait) && trig;
    we      = armed && (!r_ff.ccond || cap_hit || take);
  end

  // ==========================================================
  // apb decode
  always_comb begin
    acc    = psel & penable;
    wr     = acc & pwrite;
    if (paddr == OFS_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == OFS_CMD || paddr == OFS_TVAL) begin
      addr_ok = 1'b1;
    end else if (paddr == OFS_TMSK || paddr == OFS_CVAL) begin
      addr_ok = 1'b1;
    end else if (paddr == OFS_CMSK || paddr == OFS_GEOM) begin
      addr_ok = 1'b1;
    end else if (paddr == OFS_STAT || paddr == OFS_RADR) begin
      addr_ok = 1'b1;
    end else if (paddr == OFS_RDAT || paddr == OFS_MARK) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
    cmd_wr = wr && (paddr == OFS_CMD);
  end

  assign pready  = 1'b1;
  assign pslverr = acc & ~addr_ok;
  assign prdata  = r_ff.rdat;
  assign cross_trigger_output            = r_ff.xo;
  assign cross_trigger_input_acknowledge = r_ff.xi_ack;

  // ==========================================================
  // next-state logic
  always_comb begin
    nxt_r       = r_ff;
    nxt_r.ext_d = ext;
    win_done    = 1'b0;
    // capture sequencer
    case (r_ff.st)
      st_pre: begin
        if (we) begin
          nxt_r.cnt = cnt_inc;
          if (cnt_inc == r_ff.tpos) nxt_r.st = st_wait;
        end
      end
      st_wait: begin
        if (take) begin
          nxt_r.cnt = cnt_inc;
          if (r_ff.tpos == wmask) begin
            win_done = 1'b1;
          end else begin
            nxt_r.rem = wmask - r_ff.tpos;
            nxt_r.st  = st_post;
          end
        end else if (we) begin
          nxt_r.cnt = cnt_inc; // circular pre-trigger history
        end
      end
      st_post: begin
        if (we) begin
          nxt_r.cnt = cnt_inc;
          nxt_r.rem = r_ff.rem - AW'(1);
          if (r_ff.rem == AW'(1)) win_done = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // window advance
    if (win_done) begin
      if (r_ff.win == wlast) begin
        nxt_r.st = st_full;
      end else begin
        nxt_r.win = r_ff.win + AW'(1);
        nxt_r.cnt = '0;
        nxt_r.st  = (r_ff.tpos == '0) ? st_wait : st_pre;
      end
    end
    // trigger output handshake
    case (r_ff.omode)
      internal_to_output: ev = int_hit & (r_ff.st == st_wait);
      external_to_output: ev = ext;
      internal_or_external_to_output: ev = (int_hit & (r_ff.st == st_wait)) | ext;
      default: ev = 1'b0;
    endcase
    if (!EN_XOUT) begin
      nxt_r.xo = 1'b0;
    end else if (r_ff.xo && cross_trigger_output_acknowledge) begin
      nxt_r.xo = 1'b0;
    end else if (!r_ff.xo && ev && !cross_trigger_output_acknowledge) begin
      nxt_r.xo = 1'b1;
    end
    nxt_r.xi_ack = ext;
    // register writes
    if (wr) begin
      if (paddr == OFS_CTRL) begin
        nxt_r.tmode = tmode_t'(pwdata[CTRL_TMODE_LSB +: 3]);
        nxt_r.omode = omode_t'(pwdata[CTRL_OMODE_LSB +: 2]);
        nxt_r.ccond = pwdata[CTRL_CCOND_BIT];
        nxt_r.tcomb = comb_t'(pwdata[CTRL_TCOMB_LSB +: 2]);
        nxt_r.ccomb = comb_t'(pwdata[CTRL_CCOMB_LSB +: 2]);
      end else if (paddr == OFS_TVAL) begin
        nxt_r.tval = pwdata[DW-1:0];
      end else if (paddr == OFS_TMSK) begin
        nxt_r.tmsk = pwdata[DW-1:0];
      end else if (paddr == OFS_CVAL) begin
        nxt_r.cval = pwdata[DW-1:0];
      end else if (paddr == OFS_CMSK) begin
        nxt_r.cmsk = pwdata[DW-1:0];
      end else if (paddr == OFS_GEOM) begin
        nxt_r.wdl  = pwdata[GEOM_WDL_LSB +: 5];
        nxt_r.wcl  = pwdata[GEOM_WCL_LSB +: 5];
        nxt_r.tpos = pwdata[GEOM_TPOS_LSB +: AW];
      end else if (paddr == OFS_RADR) begin
        nxt_r.radr = pwdata[AW-1:0];
      end
    end
    // commands override the sequencer
    if (cmd_wr) begin
      if (pwdata[CMD_STOP_BIT]) begin
        nxt_r.st  = st_idle;
        nxt_r.win = '0;
        nxt_r.cnt = '0;
        nxt_r.imm = 1'b0;
      end else if (pwdata[CMD_ARM_BIT] || pwdata[CMD_IMM_BIT]) begin
        nxt_r.win = '0;
        nxt_r.cnt = '0;
        nxt_r.imm = pwdata[CMD_IMM_BIT];
        nxt_r.st  = (r_ff.tpos == '0) ? st_wait : st_pre;
      end
    end
    // read data captured in the setup phase
    if (psel && !penable && !pwrite) begin
      if (paddr == OFS_CTRL) begin
        nxt_r.rdat = 32'(r_ff.tmode) << CTRL_TMODE_LSB |
                     32'(r_ff.omode) << CTRL_OMODE_LSB |
                     32'(r_ff.ccond) << CTRL_CCOND_BIT |
                     32'(r_ff.tcomb) << CTRL_TCOMB_LSB |
                     32'(r_ff.ccomb) << CTRL_CCOMB_LSB;
      end else if (paddr == OFS_TVAL) begin
        nxt_r.rdat = 32'(r_ff.tval);
      end else if (paddr == OFS_TMSK) begin
        nxt_r.rdat = 32'(r_ff.tmsk);
      end else if (paddr == OFS_CVAL) begin
        nxt_r.rdat = 32'(r_ff.cval);
      end else if (paddr == OFS_CMSK) begin
        nxt_r.rdat = 32'(r_ff.cmsk);
      end else if (paddr == OFS_GEOM) begin
        nxt_r.rdat = 32'(r_ff.wdl) << GEOM_WDL_LSB |
                     32'(r_ff.wcl) << GEOM_WCL_LSB |
                     32'(r_ff.tpos) << GEOM_TPOS_LSB;
      end else if (paddr == OFS_STAT) begin
        nxt_r.rdat = 32'(r_ff.st) | 32'(r_ff.win) << STAT_WIN_LSB |
                     32'(r_ff.cnt) << STAT_CNT_LSB;
      end else if (paddr == OFS_RADR) begin
        nxt_r.rdat = 32'(r_ff.radr);
      end else if (paddr == OFS_RDAT) begin
        nxt_r.rdat = 32'(mem[r_ff.radr]);
      end else if (paddr == OFS_MARK) begin
        nxt_r.rdat = 32'(mark[r_ff.radr]);
      end else begin
        nxt_r.rdat = 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_ff     <= '0;
      r_ff.st  <= st_idle;
      r_ff.wdl <= 5'(AW);
      r_ff.wcl <= WCL_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // capture buffer and per-window trigger marks
  always_ff @(posedge clk_sys) begin
    if (we) mem[waddr] <= probe_data;
    if (take) mark[r_ff.win] <= r_ff.cnt;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_NO_STORE: assert property (
    (r_ff.st == st_idle || r_ff.st == st_full) |-> !we)
    else $error("sample stored while idle or full");
  AST_ALWAYS: assert property (
    armed && !r_ff.ccond |-> we)
    else $error("unconditional capture skipped a cycle");
  AST_COND: assert property (
    armed && r_ff.ccond && !cap_hit && !take |-> !we)
    else $error("conditional capture stored a false sample");
  AST_ARM_WAIT: assert property (
    cmd_wr && pwdata[CMD_ARM_BIT] && !pwdata[CMD_STOP_BIT] && r_ff.tpos == '0
    |=> r_ff.st == st_wait && r_ff.win == '0)
    else $error("arm at position zero did not wait");
  AST_ARM_PRE: assert property (
    cmd_wr && pwdata[CMD_ARM_BIT] && !pwdata[CMD_STOP_BIT] && r_ff.tpos != '0
    |=> r_ff.st == st_pre)
    else $error("arm at nonzero position skipped pre-trigger");
  AST_IMM: assert property (
    r_ff.st == st_wait && r_ff.imm |-> take)
    else $error("immediate arm did not trigger");
  AST_FULL_HOLD: assert property (
    r_ff.st == st_full && !cmd_wr |=> r_ff.st == st_full && $stable(r_ff.win))
    else $error("full buffer not held");
  AST_NEXT_WIN: assert property (
    r_ff.st == st_post && we && r_ff.rem == AW'(1) && r_ff.win != wlast &&
    r_ff.tpos == '0 && !cmd_wr |=> r_ff.st == st_wait && r_ff.cnt == '0)
    else $error("next window not ready at once");
  AST_EDGE: assert property (
    take && !r_ff.imm && r_ff.tmode == external_edge_only_mode
    |-> cross_trigger_input && !$past(cross_trigger_input))
    else $error("edge mode triggered without rising input");
  AST_XO_HOLD: assert property (
    r_ff.xo && !cross_trigger_output_acknowledge |=> r_ff.xo)
    else $error("cross-trigger output dropped before acknowledge");
  AST_XO_OFF: assert property (
    r_ff.omode == out_disabled && !r_ff.xo |=> !r_ff.xo)
    else $error("disabled output asserted");

  CV_FULL: cover property (r_ff.st == st_post ##1 r_ff.st == st_full);
  CV_WIN1: cover property (take && r_ff.win != '0);
  CV_XO: cover property (r_ff.xo ##[1:8] !r_ff.xo);
  CV_PRE: cover property (r_ff.st == st_pre ##1 r_ff.st == st_wait);

endmodule // lat_core
`default_nettype wire

// File: verif/lat_partner.sv
/*
  far-side model: user logic driving probes and a cross-triggering peer.
  assumes bench controls change just after rising edges of clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module lat_partner (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // bench controls
  input  wire logic [31:0] pval,
  input  wire logic        send,
  input  wire logic [3:0]  ack_dly,
  // toward the core
  output logic      [31:0] probe_data,
  output logic             xi,
  input  wire logic        xi_ack,
  input  wire logic        xo,
  output logic             xo_ack
);
  logic [3:0] cnt;
  // ==========================================================
  // probed nets follow the bench value
  always_ff @(posedge clk_sys) probe_data <= pval;
  // request held until acknowledged, then dropped
  always_ff @(posedge clk_sys) begin
    if (rst) xi <= 1'b0;
    else if (xi_ack) xi <= 1'b0;
    else if (send) xi <= 1'b1;
  end
  // acknowledge ack_dly+1 cycles after xo rises, dropped once released
  always_ff @(posedge clk_sys) begin
    if (rst || !xo) begin
      cnt    <= 4'h0;
      xo_ack <= 1'b0;
    end else if (cnt == ack_dly) xo_ack <= 1'b1;
    else cnt <= cnt + 4'h1;
  end
endmodule // lat_partner
`default_nettype wire

// File: verif/testbench.sv
/*
  self-checking bench: apb master tasks and directed capture tests.
  assumes lat_core and lat_partner compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import lat_pkg::*;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, send;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pval, probe_data, rd;
  logic [3:0]  ack_dly;
  logic        xi, xi_ack, xo, xo_ack, last_err;
  int          err_total, n_compared;
  int          xo_base;
  int          xo_hi = 0;
  // ==========================================================
  // design and far side
  lat_core u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .probe_data(probe_data),
    .cross_trigger_input(xi), .cross_trigger_input_acknowledge(xi_ack),
    .cross_trigger_output(xo), .cross_trigger_output_acknowledge(xo_ack));
  lat_partner u_far (.clk_sys(clk_sys), .rst(rst), .pval(pval), .send(send),
    .ack_dly(ack_dly), .probe_data(probe_data), .xi(xi), .xi_ack(xi_ack),
    .xo(xo), .xo_ack(xo_ack));
  // ==========================================================
  // clock, output watch and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // cycles with the cross-trigger output high, single driver
  always @(posedge clk_sys) begin
    if (xo === 1'b1) xo_hi <= xo_hi + 1;
  end
  initial begin
    #2000000;
    err_total++;
    finish_test();
  end
  // ==========================================================
  // tasks
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // waits for pready as long as it takes; only the watchdog ends a hang
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // poll the state field under a bounded count
  task automatic wait_st(input logic [4:0] exp);
    int n;
    n = 0;
    do begin
      xfer(OFS_STAT, 1'b0, 32'h0);
      n++;
    end while (rd[4:0] !== exp && n < 40);
    chk({27'h0, rd[4:0]}, {27'h0, exp});
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic kick();
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
  endtask
  // ==========================================================
  // tests
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pval = 32'h5a5a5a5a; send = 1'b0; ack_dly = 4'h5;
    xo_base = 0; err_total = 0; n_compared = 0;
    idle(4);
    rst <= 1'b0;
    // reset values and unmapped access
    rchk(OFS_STAT, 32'h00000001);
    rchk(OFS_GEOM, 32'h0000000a);
    rchk(OFS_CMD, 32'h00000000);
    rchk(8'h40, 32'h00000000);
    chk({31'h0, last_err}, 32'h1);
    $display("test reset done");
    // immediate arm, two windows of four, trigger never true
    wr(OFS_TMSK, 32'h000000ff);
    wr(OFS_TVAL, 32'h00000000);
    wr(OFS_GEOM, 32'h00000102);
    wr(OFS_CMD, 32'h00000002);
    wait_st(st_full);
    wr(OFS_RADR, 32'h00000005);
    rchk(OFS_RDAT, 32'h5a5a5a5a);
    pval <= 32'h11111111;
    idle(10);
    rchk(OFS_RDAT, 32'h5a5a5a5a);
    wait_st(st_full);
    $display("test immediate done");
    // normal arm waits, then both windows trigger in turn
    pval <= 32'h5a5a5a5a;
    wr(OFS_CMD, 32'h00000001);
    wait_st(st_wait);
    idle(10);
    wait_st(st_wait);
    pval <= 32'h5a5a5a00;
    wait_st(st_full);
    wr(OFS_RADR, 32'h00000001);
    rchk(OFS_MARK, 32'h00000000);
    rchk(OFS_RDAT, 32'h5a5a5a00);
    $display("test windows done");
    // conditional capture holds pre-trigger, last index goes full
    wr(OFS_CMD, 32'h00000004);
    wait_st(st_idle);
    wr(OFS_GEOM, 32'h00030002);
    wr(OFS_CMSK, 32'h0000ff00);
    wr(OFS_CVAL, 32'h00007700);
    wr(OFS_CTRL, 32'h00000040);
    wr(OFS_CMD, 32'h00000001);
    wait_st(st_pre);
    idle(10);
    wait_st(st_pre);
    pval <= 32'h00007700;
    wait_st(st_full);
    wr(OFS_RADR, 32'h00000000);
    rchk(OFS_MARK, 32'h00000003);
    $display("test conditional done");
    // edge-only mode ignores a true internal condition
    wr(OFS_CMD, 32'h00000004);
    wr(OFS_GEOM, 32'h00000002);
    wr(OFS_CTRL, 32'h00000024);
    pval <= 32'h5a5a5a00;
    wr(OFS_CMD, 32'h00000001);
    idle(10);
    wait_st(st_wait);
    xo_base = xo_hi;
    kick();
    wait_st(st_full);
    chk({31'h0, xo_hi != xo_base}, 32'h1);
    idle(20);
    chk({31'h0, xo}, 32'h0);
    $display("test edge done");
    // combined mode with output disabled
    wr(OFS_CMD, 32'h00000004);
    wr(OFS_CTRL, 32'h00000002);
    pval <= 32'h5a5a5a5a;
    wr(OFS_CMD, 32'h00000001);
    wait_st(st_wait);
    xo_base = xo_hi;
    ack_dly <= 4'h0;
    kick();
    wait_st(st_full);
    chk({31'h0, xo_hi != xo_base}, 32'h0);
    $display("test combined done");
    // nor combination true on mismatch, internal result to output
    wr(OFS_CMD, 32'h00000004);
    wr(OFS_CTRL, 32'h00000310);
    xo_base = xo_hi;
    wr(OFS_CMD, 32'h00000001);
    wait_st(st_full);
    idle(5);
    chk({31'h0, xo_hi != xo_base}, 32'h1);
    $display("test combination done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
